// *** src/wear_pkg.sv ***
// constants, bus carriers and state encoding for the breaker wear accumulator
// assumes a 20 MHz single clock domain and an AXI4-Lite master with 32-bit data
package wear_pkg;

  // --------------------------------------------------------------------------
  // bus carriers
  // --------------------------------------------------------------------------
  localparam int ADDR_W = 8;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axil_rsp_t;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // --------------------------------------------------------------------------
  // register map (byte addresses)
  // --------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNT_1KA = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COUNT_RATED = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_ALARM_THR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RATED_CUR = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MIN_CUR = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_WEAR_SUM = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_LAST_PEAK = 8'h20;

  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int STAT_ALARM_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_ABANDON_BIT = 2;

  // --------------------------------------------------------------------------
  // settings: reset values and legal ranges (currents in 0.01 kA units)
  // --------------------------------------------------------------------------
  localparam int CNT_W = 17;
  localparam int CUR_W = 16;
  localparam logic [CNT_W-1:0] COUNT_MIN = 17'h00001;
  localparam logic [CNT_W-1:0] COUNT_MAX = 17'h186a0;
  localparam logic [CNT_W-1:0] COUNT_1KA_RST = 17'h0c350;
  localparam logic [CNT_W-1:0] COUNT_RATED_RST = 17'h00064;
  localparam logic [CNT_W-1:0] ALARM_THR_RST = 17'h0c350;
  localparam logic [CUR_W-1:0] RATED_MIN = 16'h03e8;
  localparam logic [CUR_W-1:0] RATED_MAX = 16'h2710;
  localparam logic [CUR_W-1:0] RATED_RST = 16'h03e8;
  localparam logic [CUR_W-1:0] MINCUR_MIN = 16'h000a;
  localparam logic [CUR_W-1:0] MINCUR_MAX = 16'h0032;
  localparam logic [CUR_W-1:0] MINCUR_RST = 16'h000a;

  // --------------------------------------------------------------------------
  // arithmetic: Q10 logarithms, accumulator with 10 fraction bits
  // --------------------------------------------------------------------------
  localparam int FRAC_W = 10;
  localparam int DIV_W = 28;
  localparam int ACC_W = 40;
  localparam logic [CNT_W-1:0] LOG2_100_Q10 = 17'h01a40;
  localparam int EXP_MAX = 20;
  localparam int EXP_MIN = -11;

  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int SEARCH_TIMEOUT_MS = 1000;
  localparam int SEARCH_TIMEOUT_CYC = SEARCH_TIMEOUT_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {ST_IDLE, ST_SEARCH, ST_LOG, ST_DIV, ST_ADD} wear_state_t;

endpackage

// *** src/breaker_wear_accumulator.sv ***
// breaker contact wear accumulator with AXI4-Lite settings and status
// assumes phase magnitudes arrive on aclk in 0.01 kA units; binary inputs are asynchronous
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
module breaker_wear_accumulator #(
  parameter int TIMEOUT_CYC = wear_pkg::SEARCH_TIMEOUT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire wear_pkg::axil_req_t axi_req,
  output wear_pkg::axil_rsp_t axi_rsp,
  input wire logic [15:0] phase_mag_a,
  input wire logic [15:0] phase_mag_b,
  input wire logic [15:0] phase_mag_c,
  input wire logic wear_block_in,
  input wire logic breaker_open_in,
  input wire logic breaker_closed_in,
  input wire logic trip_request_in,
  input wire logic wear_clear_in,
  input wire logic nv_restore_valid,
  input wire logic [39:0] nv_restore_sum,
  output logic [39:0] wear_sum_out,
  output logic wear_sum_save,
  output logic search_active_out,
  output logic wear_alarm_out
);
  import wear_pkg::*;

  localparam int TMR_W = $clog2(TIMEOUT_CYC + 1);
  localparam int NSYNC = 5;

  // refuse a timeout the counter cannot express
  if (TIMEOUT_CYC < 1) begin : g_bad_timeout
    $error("TIMEOUT_CYC must be at least one cycle");
  end

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // log2 in Q10: leading-one position plus linear fraction, error below 0.09
  function automatic logic [CNT_W-1:0] log2q(input logic [CNT_W-1:0] x);
    logic [4:0] p;
    logic [CNT_W-1:0] sh;
    p = 5'h00;
    for (int i = 0; i < CNT_W; i++) begin
      if (x[i]) p = 5'(i);
    end
    sh = x << (5'h10 - p);
    return {2'h0, p, sh[15:6]};
  endfunction

  // apply byte strobes onto the current value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------------
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] pin_meta_r;
  logic [NSYNC-1:0] pin_sync_r;
  assign pin_raw = {wear_clear_in, trip_request_in, breaker_closed_in, breaker_open_in, wear_block_in};

  // two flops per pin; only the second stage is used by the logic
  for (genvar g = 0; g < NSYNC; g++) begin : g_sync
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_meta_r[g] <= 1'b0;
        pin_sync_r[g] <= 1'b0;
      end else begin
        pin_meta_r[g] <= pin_raw[g];
        pin_sync_r[g] <= pin_meta_r[g];
      end
    end
  end

  logic blk_s, open_s, closed_s, trip_s, clr_pin_s;
  assign {clr_pin_s, trip_s, closed_s, open_s, blk_s} = pin_sync_r;

  logic trip_d_r;
  // trip edge only, so a held trip does not retrigger after completion
  always_ff @(posedge aclk) begin
    if (!aresetn) trip_d_r <= 1'b0;
    else trip_d_r <= trip_s;
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------------
  logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r, rd_mux;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r, rd_resp;
  logic do_write, wr_hit;

  assign axi_rsp.awready = ~aw_hold_r & ~bvalid_r;
  assign axi_rsp.wready = ~w_hold_r & ~bvalid_r;
  assign axi_rsp.bvalid = bvalid_r;
  assign axi_rsp.bresp = bresp_r;
  assign axi_rsp.arready = ~rvalid_r;
  assign axi_rsp.rvalid = rvalid_r;
  assign axi_rsp.rdata = rdata_r;
  assign axi_rsp.rresp = rresp_r;
  assign do_write = aw_hold_r & w_hold_r & ~bvalid_r;

  // address and data taken in either order; response once both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (axi_req.awvalid && axi_rsp.awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= axi_req.wdata;
        wstrb_r <= axi_req.wstrb;
      end
      if (do_write) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && axi_req.bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (axi_req.arvalid && axi_rsp.arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_resp;
    end else if (rvalid_r && axi_req.rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // settings registers
  // --------------------------------------------------------------------------
  logic op_en_r, sw_clear_r;
  logic [CNT_W-1:0] n1_r, nr_r, thr_r;
  logic [CUR_W-1:0] rated_r, minc_r;
  logic [31:0] wv;

  assign wr_hit = (awaddr_r == OFS_CTRL) || (awaddr_r == OFS_STATUS) || (awaddr_r == OFS_COUNT_1KA)
               || (awaddr_r == OFS_COUNT_RATED) || (awaddr_r == OFS_ALARM_THR) || (awaddr_r == OFS_RATED_CUR)
               || (awaddr_r == OFS_MIN_CUR) || (awaddr_r == OFS_WEAR_SUM) || (awaddr_r == OFS_LAST_PEAK);

  // addressed setting with the write's byte lanes merged on
  always_comb begin
    wv = 32'(op_en_r);
    if (awaddr_r == OFS_COUNT_1KA) wv = 32'(n1_r);
    else if (awaddr_r == OFS_COUNT_RATED) wv = 32'(nr_r);
    else if (awaddr_r == OFS_ALARM_THR) wv = 32'(thr_r);
    else if (awaddr_r == OFS_RATED_CUR) wv = 32'(rated_r);
    else if (awaddr_r == OFS_MIN_CUR) wv = 32'(minc_r);
    wv = merge(wv, wdata_r, wstrb_r);
  end

  // out-of-range values are dropped, the setting keeps its old value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_en_r <= 1'b0;
      n1_r <= COUNT_1KA_RST;
      nr_r <= COUNT_RATED_RST;
      thr_r <= ALARM_THR_RST;
      rated_r <= RATED_RST;
      minc_r <= MINCUR_RST;
    end else if (do_write) begin
      if (awaddr_r == OFS_CTRL) begin
        op_en_r <= wv[CTRL_ENABLE_BIT];
      end else if (awaddr_r == OFS_COUNT_1KA) begin
        if (wv >= 32'(COUNT_MIN) && wv <= 32'(COUNT_MAX)) n1_r <= wv[CNT_W-1:0];
      end else if (awaddr_r == OFS_COUNT_RATED) begin
        if (wv >= 32'(COUNT_MIN) && wv <= 32'(COUNT_MAX)) nr_r <= wv[CNT_W-1:0];
      end else if (awaddr_r == OFS_ALARM_THR) begin
        if (wv >= 32'(COUNT_MIN) && wv <= 32'(COUNT_MAX)) thr_r <= wv[CNT_W-1:0];
      end else if (awaddr_r == OFS_RATED_CUR) begin
        if (wv >= 32'(RATED_MIN) && wv <= 32'(RATED_MAX)) rated_r <= wv[CUR_W-1:0];
      end else if (awaddr_r == OFS_MIN_CUR) begin
        if (wv >= 32'(MINCUR_MIN) && wv <= 32'(MINCUR_MAX)) minc_r <= wv[CUR_W-1:0];
      end
    end
  end

  // software clear is a one-cycle pulse from a write of one to the clear bit
  always_ff @(posedge aclk) begin
    if (!aresetn) sw_clear_r <= 1'b0;
    else sw_clear_r <= do_write && (awaddr_r == OFS_CTRL) && wstrb_r[0] && wdata_r[CTRL_CLEAR_BIT];
  end

  // --------------------------------------------------------------------------
  // peak search and wear computation
  // --------------------------------------------------------------------------
  wear_state_t state_r;
  logic run;
  logic [CUR_W-1:0] cur_max, peak_r, last_peak_r;
  logic [TMR_W-1:0] tmr_r;
  logic [$clog2(DIV_W+1)-1:0] div_cnt_r;
  logic [DIV_W-1:0] num_r;
  logic [CNT_W-1:0] div_r, rem_r, rem_sh;
  logic neg_r, abandon_r;
  logic signed [CNT_W:0] lp, lr, dn;
  logic signed [2*CNT_W+1:0] prod;
  logic [2*CNT_W+1:0] prod_abs;

  assign run = op_en_r & ~blk_s;

  // breaking current is the largest phase
  always_comb begin
    cur_max = phase_mag_a;
    if (phase_mag_b > cur_max) cur_max = phase_mag_b;
    if (phase_mag_c > cur_max) cur_max = phase_mag_c;
  end

  // logs relative to 1 kA; slope numerator from the two count points
  always_comb begin
    lp = $signed({1'b0, log2q({1'b0, peak_r})}) - $signed({1'b0, LOG2_100_Q10});
    lr = $signed({1'b0, log2q({1'b0, rated_r})}) - $signed({1'b0, LOG2_100_Q10});
    dn = $signed({1'b0, log2q(n1_r)}) - $signed({1'b0, log2q(nr_r)});
    prod = lp * dn;
    prod_abs = prod[2*CNT_W+1] ? 36'(-prod) : 36'(prod);
    rem_sh = {rem_r[CNT_W-2:0], num_r[DIV_W-1]};
  end

  // state sequence; any suspension drops the search without wear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
    end else if (!run) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: if (trip_s && !trip_d_r && closed_s) state_r <= ST_SEARCH;
        ST_SEARCH: begin
          if (tmr_r >= TMR_W'(TIMEOUT_CYC - 1)) state_r <= ST_IDLE;
          else if (open_s && cur_max < minc_r) state_r <= ST_LOG;
        end
        ST_LOG: state_r <= (peak_r == '0) ? ST_IDLE : ST_DIV;
        ST_DIV: if (div_cnt_r == '0) state_r <= ST_ADD;
        ST_ADD: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // peak tracking and search timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peak_r <= '0;
      tmr_r <= '0;
    end else if (state_r == ST_IDLE) begin
      peak_r <= '0;
      tmr_r <= '0;
    end else if (state_r == ST_SEARCH) begin
      tmr_r <= tmr_r + TMR_W'(1);
      if (cur_max > peak_r) peak_r <= cur_max;
    end
  end

  // status of the last search and its peak
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      abandon_r <= 1'b0;
      last_peak_r <= '0;
    end else if (run && state_r == ST_SEARCH && tmr_r >= TMR_W'(TIMEOUT_CYC - 1)) begin
      abandon_r <= 1'b1;
    end else if (run && state_r == ST_SEARCH && open_s && cur_max < minc_r) begin
      abandon_r <= 1'b0;
      last_peak_r <= (cur_max > peak_r) ? cur_max : peak_r;
    end
  end

  // serial restoring divide: exponent = lp * dn / lr, Q10; one bit per cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      num_r <= '0;
      div_r <= '0;
      rem_r <= '0;
      neg_r <= 1'b0;
      div_cnt_r <= '0;
    end else if (state_r == ST_LOG) begin
      num_r <= prod_abs[DIV_W-1:0];
      div_r <= lr[CNT_W-1:0];
      rem_r <= '0;
      neg_r <= lp[CNT_W] ^ dn[CNT_W];
      div_cnt_r <= ($clog2(DIV_W+1))'(DIV_W - 1);
    end else if (state_r == ST_DIV) begin
      div_cnt_r <= div_cnt_r - 1'b1;
      if (rem_sh >= div_r) begin
        rem_r <= rem_sh - div_r;
        num_r <= {num_r[DIV_W-2:0], 1'b1};
      end else begin
        rem_r <= rem_sh;
        num_r <= {num_r[DIV_W-2:0], 1'b0};
      end
    end
  end

  // increment = 2^exponent with linear fraction, in Q10 1 kA operations
  logic signed [DIV_W:0] expo;
  logic signed [DIV_W-FRAC_W:0] ip;
  logic [FRAC_W:0] mant;
  logic [ACC_W-1:0] inc;
  always_comb begin
    expo = neg_r ? -$signed({1'b0, num_r}) : $signed({1'b0, num_r});
    ip = expo[DIV_W:FRAC_W];
    mant = {1'b1, expo[FRAC_W-1:0]};
    if (ip > EXP_MAX) inc = '1;
    else if (ip < EXP_MIN) inc = '0;
    else if (ip >= 0) inc = ACC_W'(mant) << ip[4:0];
    else inc = ACC_W'(mant) >> 5'(-ip);
  end

  // --------------------------------------------------------------------------
  // accumulated wear and alarm
  // --------------------------------------------------------------------------
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W:0] acc_sum;
  logic clr, clr_d_r, above, save_r, alarm_r;
  assign clr = clr_pin_s | sw_clear_r;
  assign acc_sum = {1'b0, acc_r} + {1'b0, inc};
  assign above = acc_r[ACC_W-1:FRAC_W] > (ACC_W - FRAC_W)'(thr_r);

  // clear beats restore beats add; saturates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= '0;
      save_r <= 1'b0;
    end else begin
      save_r <= 1'b0;
      if (clr) begin
        acc_r <= '0;
        save_r <= 1'b1;
      end else if (nv_restore_valid) begin
        acc_r <= nv_restore_sum;
      end else if (run && state_r == ST_ADD) begin
        acc_r <= acc_sum[ACC_W] ? '1 : acc_sum[ACC_W-1:0];
        save_r <= 1'b1;
      end
    end
  end

  // alarm sets when above, drops only after a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clr_d_r <= 1'b0;
      alarm_r <= 1'b0;
    end else begin
      clr_d_r <= clr;
      if (above) alarm_r <= 1'b1;
      else if (clr_d_r) alarm_r <= 1'b0;
    end
  end

  assign wear_sum_out = acc_r;
  assign wear_sum_save = save_r;
  assign wear_alarm_out = alarm_r;
  assign search_active_out = (state_r != ST_IDLE);

  // read decode; unmapped gives zero and an error
  always_comb begin
    rd_mux = '0;
    rd_resp = RESP_OKAY;
    if (axi_req.araddr == OFS_CTRL) begin
      rd_mux[CTRL_ENABLE_BIT] = op_en_r;
    end else if (axi_req.araddr == OFS_STATUS) begin
      rd_mux[STAT_ALARM_BIT] = alarm_r;
      rd_mux[STAT_BUSY_BIT] = (state_r != ST_IDLE);
      rd_mux[STAT_ABANDON_BIT] = abandon_r;
    end else if (axi_req.araddr == OFS_COUNT_1KA) begin
      rd_mux = 32'(n1_r);
    end else if (axi_req.araddr == OFS_COUNT_RATED) begin
      rd_mux = 32'(nr_r);
    end else if (axi_req.araddr == OFS_ALARM_THR) begin
      rd_mux = 32'(thr_r);
    end else if (axi_req.araddr == OFS_RATED_CUR) begin
      rd_mux = 32'(rated_r);
    end else if (axi_req.araddr == OFS_MIN_CUR) begin
      rd_mux = 32'(minc_r);
    end else if (axi_req.araddr == OFS_WEAR_SUM) begin
      rd_mux = 32'(acc_r[ACC_W-1:FRAC_W]);
    end else if (axi_req.araddr == OFS_LAST_PEAK) begin
      rd_mux = 32'(last_peak_r);
    end else begin
      rd_resp = RESP_SLVERR;
    end
  end

endmodule

// *** bench/wear_checker.sv ***
// port assertions for the breaker wear accumulator
// bound to the design, timeout from the instance
module wear_checker #(
  parameter int TIMEOUT_CYC = 200
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire wear_pkg::axil_req_t axi_req,
  input wire wear_pkg::axil_rsp_t axi_rsp,
  input wire logic wear_block_in,
  input wire logic breaker_closed_in,
  input wire logic wear_clear_in,
  input wire logic nv_restore_valid,
  input wire logic [39:0] wear_sum_out,
  input wire logic wear_sum_save,
  input wire logic search_active_out,
  input wire logic wear_alarm_out
);
  import wear_pkg::*;
  logic [31:0] busy_cnt_r;
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // busy spell length
  always_ff @(posedge aclk) begin
    if (!aresetn || !search_active_out) begin
      busy_cnt_r <= '0;
    end else begin
      busy_cnt_r <= busy_cnt_r + 32'h1;
    end
  end
  property p_clear_zeroes; wear_clear_in [*4] |=> wear_sum_out == '0; endproperty
  a_clear_zeroes: assert property (p_clear_zeroes) else $error("sum kept after clear");
  property p_alarm_drop; $fell(wear_alarm_out) |-> wear_sum_out == '0; endproperty
  a_alarm_drop: assert property (p_alarm_drop) else $error("alarm dropped without clear");
  property p_zero_quiet; (wear_sum_out == '0) [*3] |-> !wear_alarm_out; endproperty
  a_zero_quiet: assert property (p_zero_quiet) else $error("alarm on empty sum");
  property p_save; $changed(wear_sum_out) && !$past(nv_restore_valid) |-> ##[0:1] wear_sum_save; endproperty
  a_save: assert property (p_save) else $error("sum change not saved");
  property p_block; wear_block_in [*6] |-> !search_active_out; endproperty
  a_block: assert property (p_block) else $error("busy while blocked");
  property p_closed; (!breaker_closed_in) [*6] |=> !$rose(search_active_out); endproperty
  a_closed: assert property (p_closed) else $error("search while not closed");
  property p_bounded; busy_cnt_r <= TIMEOUT_CYC + 40; endproperty
  a_bounded: assert property (p_bounded) else $error("search too long");
  property p_wr_answer; axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |-> ##2 axi_rsp.bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");
  property p_rd_answer; axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read response late");
  c_search: cover property ($rose(search_active_out));
  c_alarm: cover property ($rose(wear_alarm_out));
  c_save: cover property (wear_sum_save);
endmodule

bind breaker_wear_accumulator wear_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_checker (
  .aclk, .aresetn, .axi_req, .axi_rsp, .wear_block_in, .breaker_closed_in, .wear_clear_in,
  .nv_restore_valid, .wear_sum_out, .wear_sum_save, .search_active_out, .wear_alarm_out);

// *** bench/fault_event_model.sv ***
// far side: trip logic, breaker contacts and current measurement for one fault
// on aclk; go starts an interruption, busy until reclose
module fault_event_model (
  input wire logic aclk,
  input wire logic go,
  input wire logic [15:0] pk_a,
  input wire logic [15:0] pk_b,
  input wire logic [15:0] pk_c,
  input wire logic [15:0] arc_len,
  input wire logic start_open,
  output logic [15:0] phase_mag_a,
  output logic [15:0] phase_mag_b,
  output logic [15:0] phase_mag_c,
  output logic trip_request_in,
  output logic breaker_open_in,
  output logic breaker_closed_in,
  output logic busy
);
  logic [15:0] t_r = '0;
  logic busy_r = 1'b0;
  logic arc;
  // ------------------------------------------------------------
  // event timeline
  // ------------------------------------------------------------
  // arc_len stretches the arc
  always_ff @(posedge aclk) begin
    if (go) begin
      busy_r <= 1'b1;
      t_r <= '0;
    end else if (busy_r) begin
      busy_r <= t_r < arc_len + 16'h0046;
      t_r <= t_r + 16'h0001;
    end
  end
  // trip held ten cycles for the synchroniser
  assign trip_request_in = busy_r && t_r < 16'h000a;
  // contacts part at cycle 20; start_open: never closed
  assign breaker_closed_in = !start_open && !(busy_r && t_r >= 16'h0014);
  assign breaker_open_in = !breaker_closed_in;
  // arc current lasts arc_len + 20 cycles, ending arc_len cycles after the contacts part
  assign arc = busy_r && t_r < arc_len + 16'h0014;
  assign phase_mag_a = arc ? pk_a : '0;
  assign phase_mag_b = arc ? pk_b : '0;
  assign phase_mag_c = arc ? pk_c : '0;
  assign busy = busy_r;
endmodule

// *** bench/breaker_wear_accumulator_tb.sv ***
// self-checking bench for the breaker wear accumulator
// AXI4-Lite settings, far-side model events
module breaker_wear_accumulator_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import wear_pkg::*;
  localparam int TMO = 200;
  localparam real wear_k = $ln(50000.0 / 100.0) / $ln(10.0);
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
    logic [15:0] pk;
  } row_t;
  // phases in 0.01 kA, then peak
  row_t rows [4] = '{64'h0064_0032_0014_0064, 64'h001e_00c8_000a_00c8,
    64'h0000_0028_03e8_03e8, 64'h0032_0032_0032_0032};
  logic [39:0] defs [6] = '{40'h00_00000000, 40'h08_0000c350, 40'h0c_00000064,
    40'h10_0000c350, 40'h14_000003e8, 40'h18_0000000a};
  // address, written, read back
  logic [71:0] wrs [8] = '{72'h08_000186a1_0000c350, 72'h08_000186a0_000186a0,
    72'h0c_00000000_00000064, 72'h10_00000001_00000001, 72'h14_000003e7_000003e8,
    72'h14_00002710_00002710, 72'h18_00000033_0000000a, 72'h18_00000032_00000032};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  axil_req_t req = '0;
  axil_rsp_t rsp;
  logic [15:0] pk_a = '0, pk_b = '0, pk_c = '0, arc_len = 16'h0014;
  logic go = 1'b0, start_open = 1'b0, wear_block_in = 1'b0, wear_clear_in = 1'b0;
  logic nv_restore_valid = 1'b0;
  logic [39:0] nv_restore_sum = '0;
  logic [15:0] phase_mag_a, phase_mag_b, phase_mag_c;
  logic trip_request_in, breaker_open_in, breaker_closed_in, ev_busy;
  logic [39:0] wear_sum_out, sum0;
  logic search_active_out, wear_alarm_out;
  logic [31:0] rd_d;
  logic [1:0] rd_r;
  int errors = 0, samples_checked = 0, i;
  always #25 aclk = ~aclk;
  breaker_wear_accumulator #(.TIMEOUT_CYC(TMO)) u_dut (
    .aclk, .aresetn, .axi_req(req), .axi_rsp(rsp), .phase_mag_a, .phase_mag_b, .phase_mag_c,
    .wear_block_in, .breaker_open_in, .breaker_closed_in, .trip_request_in, .wear_clear_in,
    .nv_restore_valid, .nv_restore_sum, .wear_sum_out, .wear_sum_save(), .search_active_out,
    .wear_alarm_out);
  fault_event_model u_far (
    .aclk, .go, .pk_a, .pk_b, .pk_c, .arc_len, .start_open, .phase_mag_a, .phase_mag_b,
    .phase_mag_c, .trip_request_in, .breaker_open_in, .breaker_closed_in, .busy(ev_busy));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic conclude();
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // log approximations: a band is allowed
  task automatic chk_r(input string nm, input real e, input real s);
    samples_checked++;
    if (s < e * 0.92 - 0.02 || s > e * 1.08 + 0.02) begin
      errors++;
      $display("unexpected %s expected %f seen %f", nm, e, s);
    end
  endtask
  // each channel held until its handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    rd_r = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    rd_d = rsp.rdata;
    rd_r = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  // one interruption, checked mid-arc
  task automatic ev(input logic act);
    sum0 = wear_sum_out;
    @(posedge aclk);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (30) @(posedge aclk);
    @(negedge aclk);
    chk("searching", act, search_active_out);
    while (ev_busy) @(posedge aclk);
  endtask
  // ------------------------------------------------------------
  // sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    #500000;
    errors++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    wr(OFS_CTRL, 32'h1);
    for (i = 0; i < 4; i++) begin
      {pk_a, pk_b, pk_c} <= {rows[i].a, rows[i].b, rows[i].c};
      ev(1'b1);
      rd(OFS_LAST_PEAK);
      chk("peak", rows[i].pk, rd_d);
      chk_r("wear", (rows[i].pk / 100.0) ** wear_k, (wear_sum_out - sum0) / 1024.0);
    end
    wr(OFS_ALARM_THR, 32'h64);
    repeat (4) @(posedge aclk);
    chk("alarm", 1, wear_alarm_out);
    wr(OFS_ALARM_THR, 32'h186a0);
    repeat (4) @(posedge aclk);
    chk("alarm", 1, wear_alarm_out);
    wear_clear_in <= 1'b1;
    repeat (6) @(posedge aclk);
    wear_clear_in <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("sum", 0, wear_sum_out);
    chk("alarm", 0, wear_alarm_out);
    nv_restore_sum <= 40'h2c00;
    nv_restore_valid <= 1'b1;
    @(posedge aclk);
    nv_restore_valid <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("restored", 40'h2c00, wear_sum_out);
    pk_a <= 16'h01f4;
    wear_block_in <= 1'b1;
    ev(1'b0);
    chk("blocked", 40'h2c00, wear_sum_out);
    wear_block_in <= 1'b0;
    start_open <= 1'b1;
    ev(1'b0);
    chk("not closed", 40'h2c00, wear_sum_out);
    start_open <= 1'b0;
    arc_len <= 16'h0190;
    ev(1'b1);
    rd(OFS_STATUS);
    chk("abandoned", 1, rd_d[STAT_ABANDON_BIT]);
    chk("timed out", 40'h2c00, wear_sum_out);
    arc_len <= 16'h0014;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 6; i++) begin
      rd(defs[i][39:32]);
      chk("default", defs[i][31:0], rd_d);
    end
    rd(8'h3c);
    chk("unmapped", RESP_SLVERR, rd_r);
    ev(1'b0);
    chk("disabled", 0, wear_sum_out);
    for (i = 0; i < 8; i++) begin
      wr(wrs[i][71:64], wrs[i][63:32]);
      rd(wrs[i][71:64]);
      chk("setting", wrs[i][31:0], rd_d);
    end
    conclude();
  end
endmodule
